/* File: core/irs_defs.vh */
`ifndef IRS_DEFS_VH
`define IRS_DEFS_VH

// ------------------------------------------------------------
// Link addressing
// ------------------------------------------------------------
`define IRS_SLAVE_ADDR   7'h6b
`define IRS_MCODE_PREFIX 5'h01
`define IRS_RW_READ      1'b1

// ------------------------------------------------------------
// Bit counter positions within one byte frame
// ------------------------------------------------------------
`define IRS_CNT_ZERO     4'h0
`define IRS_CNT_LAST_TX  4'h7
`define IRS_CNT_BYTE     4'h8
`define IRS_CNT_ACK      4'h9

// ------------------------------------------------------------
// Register space
// ------------------------------------------------------------
`define IRS_ADDR_W       8
`define IRS_DATA_W       8
`define IRS_PTR_RESET    8'h00
`define IRS_BYTE_RESET   8'h00

// ------------------------------------------------------------
// Timing: system clock against fastest link clock
// ------------------------------------------------------------
`define IRS_CLK_HZ       50000000
`define IRS_HS_SCL_HZ    3400000
`define IRS_FS_SCL_HZ    1000000
`define IRS_SYNC_STAGES  2

`endif

/* File: core/irs_regmem.v */
// ------------------------------------------------------------
// Register file storage, two ports, registered read data
// ------------------------------------------------------------
module irs_regmem #(
  parameter ADDR_W = 8,
  parameter DATA_W = 8
) (
  input  wire              clk,
  input  wire              link_we,
  input  wire [ADDR_W-1:0] link_waddr,
  input  wire [DATA_W-1:0] link_wdata,
  input  wire [ADDR_W-1:0] link_raddr,
  output reg  [DATA_W-1:0] link_rdata_q,
  input  wire              loc_we,
  input  wire [ADDR_W-1:0] loc_addr,
  input  wire [DATA_W-1:0] loc_wdata,
  output reg  [DATA_W-1:0] loc_rdata_q
);

  reg [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  // ------------------------------------------------------------
  // Writes: link port wins a same-address collision
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (loc_we && !(link_we && (link_waddr == loc_addr))) begin
      mem[loc_addr] <= loc_wdata;
    end
    if (link_we) begin
      mem[link_waddr] <= link_wdata;
    end
  end

  // ------------------------------------------------------------
  // Reads
  // ------------------------------------------------------------
  always @(posedge clk) begin
    link_rdata_q <= mem[link_raddr];
    loc_rdata_q  <= mem[loc_addr];
  end

endmodule

/* File: core/irs_slave.v */
// Overview of operation
// [R1] Clock line is input only; data line is pulled low or released.
// [R2] Data line pulled low only for read data or acknowledge.
// [R3] Bytes move most significant bit first, bit 7 to bit 0.
// [R4] Respond only to slave address 1101011 plus direction bit.
// [R5] Each incoming data bit sampled at the clock rising edge.
// [R6] Master changes data while clock is low, after falling edge.
// [R7] Start: data falls while clock high; device detects it.
// [R8] Stop: data rises while clock high; device returns to idle.
// [R9] Read: write address, register address, repeated start, read.
// [R10] Master code 00001XXX after a start begins high-speed mode.
// [R11] Master code is never acknowledged; data line stays released.
// [R12] Repeated start after master code enters high-speed timing.
// [R13] High-speed mode lasts until stop; packets split by restarts.
// [R14] Acknowledge each received byte by pulling data low in clock 9.
// [R15] Sequential write commits each byte at falling edge of bit 8.
// [R16] 8-bit pointer loaded from register address, bumped per write.
// [R17] Master waits for final write acknowledge before its stop.
// [R18] Master acknowledge on read byte brings next sequential register.
// [R19] Pointer increments after every byte read, wrapping the space.
// [R20] Master not-acknowledge ends driving; wait for stop or restart.
// [R21] Foreign address: ignore bytes, release data until start or stop.
`include "irs_defs.vh"

module irs_slave #(
  parameter       ADDR_W     = `IRS_ADDR_W,
  parameter       DATA_W     = `IRS_DATA_W,
  parameter [6:0] SLAVE_ADDR = `IRS_SLAVE_ADDR
) (
  input  wire              clk,
  input  wire              rst,
  input  wire              scl_i,
  input  wire              sda_i,
  output reg               sda_o_q,
  output reg               sda_oe_q,
  input  wire              loc_we,
  input  wire [ADDR_W-1:0] loc_addr,
  input  wire [DATA_W-1:0] loc_wdata,
  output wire [DATA_W-1:0] loc_rdata_q,
  output reg               wr_stb_q,
  output reg  [ADDR_W-1:0] wr_addr_q,
  output reg  [DATA_W-1:0] wr_data_q,
  output reg               rd_stb_q,
  output reg               hs_mode_q,
  output reg               selected_q
);

  // ------------------------------------------------------------
  // States
  // ------------------------------------------------------------
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_DEV  = 6'h02;
  localparam [5:0] ST_REG  = 6'h04;
  localparam [5:0] ST_WR   = 6'h08;
  localparam [5:0] ST_RD   = 6'h10;
  localparam [5:0] ST_WAIT = 6'h20;

  // ------------------------------------------------------------
  // Byte classification
  // ------------------------------------------------------------
  function is_mcode;
    input [7:0] b;
    begin
      is_mcode = (b[7:3] == `IRS_MCODE_PREFIX);
    end
  endfunction

  function is_own_addr;
    input [7:0] b;
    begin
      is_own_addr = (b[7:1] == SLAVE_ADDR);
    end
  endfunction

  // Pointer step, wrapping from the top of the space to zero
  function [ADDR_W-1:0] ptr_next;
    input [ADDR_W-1:0] p;
    begin
      ptr_next = p + {{(ADDR_W-1){1'b0}}, 1'b1};
    end
  endfunction

  // Open drain: only a zero bit pulls the line
  function pull_for;
    input b;
    begin
      pull_for = ~b;
    end
  endfunction

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  reg              scl_m_q;
  reg              scl_s_q;
  reg              scl_p_q;
  reg              sda_m_q;
  reg              sda_s_q;
  reg              sda_p_q;
  reg  [5:0]       state_q;
  reg  [3:0]       cnt_q;
  reg  [7:0]       rx_q;
  reg  [7:0]       tx_q;
  reg  [ADDR_W-1:0] ptr_q;
  reg              mack_q;
  reg              hs_pend_q;
  reg              mem_we_q;
  wire [DATA_W-1:0] mem_rdata;
  wire             scl_rise;
  wire             scl_fall;
  wire             start_det;
  wire             stop_det;
  reg              counting;

  // ------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ------------------------------------------------------------
  // Clock pin: two stages, then one of history for edges
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
    end else begin
      scl_m_q <= scl_i; // [R1]
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
    end
  end

  // Data pin: same depth keeps start and stop aligned with the clock
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      sda_m_q <= sda_i;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
    end
  end

  assign scl_rise  = scl_s_q & ~scl_p_q;
  assign scl_fall  = ~scl_s_q & scl_p_q;
  // Data edges only count as framing while the clock stays high
  assign start_det = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q; // [R7]
  assign stop_det  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q; // [R8]

  // Bit counting only while a byte frame is tracked
  always @* begin
    case (state_q)
      ST_DEV, ST_REG, ST_WR, ST_RD: counting = 1'b1;
      default:                      counting = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------
  irs_regmem #(
    .ADDR_W (ADDR_W),
    .DATA_W (DATA_W)
  ) u_regmem (
    .clk          (clk),
    .link_we      (mem_we_q),
    .link_waddr   (wr_addr_q),
    .link_wdata   (wr_data_q),
    .link_raddr   (ptr_q),
    .link_rdata_q (mem_rdata),
    .loc_we       (loc_we),
    .loc_addr     (loc_addr),
    .loc_wdata    (loc_wdata),
    .loc_rdata_q  (loc_rdata_q)
  );

  // ------------------------------------------------------------
  // Bit counter, cleared by start or stop
  // ------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= `IRS_CNT_ZERO;
    end else if (start_det || stop_det) begin
      cnt_q <= `IRS_CNT_ZERO;
    end else if (counting && scl_rise) begin
      if (cnt_q < `IRS_CNT_BYTE) begin
        cnt_q <= cnt_q + 4'h1;
      end else if (cnt_q == `IRS_CNT_BYTE) begin
        cnt_q <= `IRS_CNT_ACK;
      end
    end else if (counting && scl_fall && cnt_q == `IRS_CNT_ACK) begin
      cnt_q <= `IRS_CNT_ZERO;
    end
  end

  // ------------------------------------------------------------
  // Receive shifter and master acknowledge capture
  // ------------------------------------------------------------
  // Start and stop need a steady high clock, so no rise collides
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_q   <= `IRS_BYTE_RESET;
      mack_q <= 1'b1;
    end else if (counting && scl_rise) begin
      if (cnt_q < `IRS_CNT_BYTE) begin
        rx_q <= {rx_q[6:0], sda_s_q}; // [R3] [R5]
      end else if (cnt_q == `IRS_CNT_BYTE) begin
        mack_q <= sda_s_q; // [R18]
      end
    end
  end

  // ------------------------------------------------------------
  // Open-drain output level: never drives high
  // ------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sda_o_q <= 1'b0;
    end else begin
      sda_o_q <= 1'b0; // [R1]
    end
  end

  // ------------------------------------------------------------
  // Transaction sequencer
  // ------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q    <= ST_IDLE;
      sda_oe_q   <= 1'b0;
      tx_q       <= `IRS_BYTE_RESET;
      ptr_q      <= `IRS_PTR_RESET;
      hs_pend_q  <= 1'b0;
      hs_mode_q  <= 1'b0;
      selected_q <= 1'b0;
      mem_we_q   <= 1'b0;
      wr_stb_q   <= 1'b0;
      wr_addr_q  <= `IRS_PTR_RESET;
      wr_data_q  <= `IRS_BYTE_RESET;
      rd_stb_q   <= 1'b0;
    end else begin
      mem_we_q <= 1'b0;
      wr_stb_q <= 1'b0;
      rd_stb_q <= 1'b0;
      if (stop_det) begin
        state_q    <= ST_IDLE; // [R8]
        sda_oe_q   <= 1'b0;
        hs_pend_q  <= 1'b0;
        hs_mode_q  <= 1'b0; // [R13]
        selected_q <= 1'b0;
      end else if (start_det) begin
        state_q    <= ST_DEV; // [R7] [R9]
        sda_oe_q   <= 1'b0;
        hs_pend_q  <= 1'b0;
        selected_q <= 1'b0;
        if (hs_pend_q) begin
          hs_mode_q <= 1'b1; // [R12]
        end
      end else if (scl_fall) begin
        case (state_q)
          ST_DEV: begin
            if (cnt_q == `IRS_CNT_BYTE) begin
              if (is_mcode(rx_q)) begin
                // No acknowledge, wait for the restart
                state_q   <= ST_WAIT; // [R10] [R11]
                hs_pend_q <= 1'b1;
              end else if (is_own_addr(rx_q)) begin
                sda_oe_q   <= 1'b1; // [R4] [R14]
                selected_q <= 1'b1;
              end else begin
                state_q <= ST_WAIT; // [R21]
              end
            end else if (cnt_q == `IRS_CNT_ACK) begin
              sda_oe_q <= 1'b0;
              // First read byte comes from the current pointer
              if (rx_q[0] == `IRS_RW_READ) begin
                state_q  <= ST_RD;
                tx_q     <= mem_rdata;
                sda_oe_q <= pull_for(mem_rdata[7]); // [R2] [R3]
              end else begin
                state_q <= ST_REG;
              end
            end
          end
          ST_REG: begin
            if (cnt_q == `IRS_CNT_BYTE) begin
              ptr_q    <= rx_q; // [R16]
              sda_oe_q <= 1'b1; // [R14]
            end else if (cnt_q == `IRS_CNT_ACK) begin
              sda_oe_q <= 1'b0;
              state_q  <= ST_WR;
            end
          end
          ST_WR: begin
            if (cnt_q == `IRS_CNT_BYTE) begin
              mem_we_q  <= 1'b1; // [R15]
              wr_stb_q  <= 1'b1;
              wr_addr_q <= ptr_q;
              wr_data_q <= rx_q;
              ptr_q     <= ptr_next(ptr_q); // [R16]
              sda_oe_q  <= 1'b1; // [R14]
            end else if (cnt_q == `IRS_CNT_ACK) begin
              sda_oe_q <= 1'b0; // [R17]
            end
          end
          ST_RD: begin
            if (cnt_q == `IRS_CNT_BYTE) begin
              sda_oe_q <= 1'b0; // [R2]
              ptr_q    <= ptr_next(ptr_q); // [R19]
              rd_stb_q <= 1'b1;
            end else if (cnt_q == `IRS_CNT_ACK) begin
              // Master acknowledge asks for the next register
              if (!mack_q) begin
                tx_q     <= mem_rdata; // [R18]
                sda_oe_q <= pull_for(mem_rdata[7]); // [R3]
              end else begin
                state_q  <= ST_WAIT; // [R20]
                sda_oe_q <= 1'b0;
              end
            end else if (cnt_q <= `IRS_CNT_LAST_TX) begin
              tx_q     <= {tx_q[6:0], 1'b0}; // [R3]
              sda_oe_q <= pull_for(tx_q[6]); // [R2]
            end
          end
          ST_WAIT: begin
            sda_oe_q <= 1'b0; // [R20] [R21]
          end
          default: begin
            sda_oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

/* File: tb/irs_checker.sv */
module irs_checker #(
  parameter ADDR_W = 8,
  parameter DATA_W = 8
) (
  input logic              clk,
  input logic              rst,
  input logic              scl_i,
  input logic              sda_i,
  input logic              sda_o_q,
  input logic              sda_oe_q,
  input logic              loc_we,
  input logic [ADDR_W-1:0] loc_addr,
  input logic [DATA_W-1:0] loc_wdata,
  input logic [DATA_W-1:0] loc_rdata_q,
  input logic              wr_stb_q,
  input logic [ADDR_W-1:0] wr_addr_q,
  input logic [DATA_W-1:0] wr_data_q,
  input logic              rd_stb_q,
  input logic              hs_mode_q,
  input logic              selected_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_stop;
    $rose(sda_i) && scl_i && $past(scl_i);
  endsequence
  sequence s_idle;
    !hs_mode_q && !selected_q && !sda_oe_q;
  endsequence
  a_oe_pulls_low: assert property (sda_oe_q |-> !sda_o_q)
    else $error("data pin driven high");
  a_oe_scl_low: assert property ($changed(sda_oe_q) |-> !scl_i)
    else $error("data pin changed with clock high");
  a_stop_idle: assert property (s_stop |-> ##[1:6] s_idle)
    else $error("no return to idle after stop");
  a_wr_ack: assert property (wr_stb_q |-> sda_oe_q[*7])
    else $error("write byte ack too short");
  a_wr_pulse: assert property (wr_stb_q |=> !wr_stb_q && $stable(wr_data_q))
    else $error("write strobe longer than one cycle");
  a_rd_release: assert property (rd_stb_q |-> !sda_oe_q ##1 !rd_stb_q)
    else $error("data pin held in master ack slot");
  a_hs_clear: assert property ($fell(hs_mode_q) |-> !selected_q)
    else $error("high speed left inside a packet");
  a_foreign_quiet: assert property (wr_stb_q |-> selected_q)
    else $error("byte taken while not selected");
endmodule

/* File: tb/irs_host_model.sv */
module irs_host_model (
  output logic scl,
  output logic sda,
  input  logic dev_pull
);
  timeunit 1ns;
  timeprecision 1ns;
  int   q = 40;
  logic pull_q = 1'b0;
  initial scl = 1'b1;
  // Pull-up: line high unless someone pulls
  assign sda = ~(pull_q | dev_pull);
  task automatic put_bit(input logic b);
    pull_q = ~b;
    #(q) scl = 1'b1;
    #(2*q) scl = 1'b0;
    #(q);
  endtask
  task automatic get_bit(output logic b);
    pull_q = 1'b0;
    #(q) scl = 1'b1;
    #(q) b = sda;
    #(q) scl = 1'b0;
    #(q);
  endtask
  task automatic start;
    #3 pull_q = 1'b0;
    #(q) scl = 1'b1;
    #(2*q) pull_q = 1'b1;
    #(2*q) scl = 1'b0;
    #20;
  endtask
  task automatic stop;
    #3 pull_q = 1'b1;
    #(q) scl = 1'b1;
    #(2*q) pull_q = 1'b0;
    #(2*q);
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) put_bit(b[i]);
    get_bit(ack);
  endtask
  task automatic recv_byte(input logic mack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(~mack);
  endtask
endmodule

/* File: tb/test_i2c_register_slave.sv */
module test_i2c_register_slave;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk, rst, scl, sda, sda_o_q, sda_oe_q, wr_stb_q, rd_stb_q;
  logic       hs_mode_q, selected_q, loc_we, ak;
  logic [7:0] loc_addr, loc_wdata, loc_rdata_q, wr_addr_q, wr_data_q, d;
  int         num_errors = 0;
  int         n_compared = 0;
  int         cyc = 0;
  irs_slave dut_u (.clk, .rst, .scl_i(scl), .sda_i(sda), .sda_o_q,
    .sda_oe_q, .loc_we, .loc_addr, .loc_wdata, .loc_rdata_q, .wr_stb_q,
    .wr_addr_q, .wr_data_q, .rd_stb_q, .hs_mode_q, .selected_q);
  irs_host_model host_u (.scl, .sda, .dev_pull(sda_oe_q));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      num_errors++;
      wrap_up;
    end
  end
  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task snd(input logic [7:0] b, input logic e);
    host_u.send_byte(b, ak);
    check({7'h00, ak}, {7'h00, e});
  endtask
  task rd_loc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) loc_addr <= a;
    repeat (2) @(posedge clk);
    #1 check(loc_rdata_q, e);
  endtask
  task t_write;
    host_u.start;
    snd(8'hd6, 1'b0);
    snd(8'hfe, 1'b0);
    snd(8'ha5, 1'b0);
    snd(8'h3c, 1'b0);
    snd(8'h81, 1'b0);
    host_u.stop;
    check(wr_addr_q, 8'h00);
    check(wr_data_q, 8'h81);
    rd_loc(8'hfe, 8'ha5);
    rd_loc(8'hff, 8'h3c);
    rd_loc(8'h00, 8'h81);
    $display("t_write done");
  endtask
  task t_read;
    host_u.start;
    snd(8'hd6, 1'b0);
    snd(8'hfe, 1'b0);
    host_u.start;
    snd(8'hd7, 1'b0);
    host_u.recv_byte(1'b1, d);
    check(d, 8'ha5);
    host_u.recv_byte(1'b1, d);
    check(d, 8'h3c);
    host_u.recv_byte(1'b0, d);
    check(d, 8'h81);
    #40 check({7'h00, sda_oe_q}, 8'h00);
    host_u.stop;
    $display("t_read done");
  endtask
  task t_foreign;
    host_u.start;
    snd(8'hd4, 1'b1);
    snd(8'h00, 1'b1);
    host_u.stop;
    check({7'h00, selected_q}, 8'h00);
    $display("t_foreign done");
  endtask
  task t_hs;
    for (int k = 0; k < 8; k++) begin
      host_u.q = 300;
      host_u.start;
      snd({5'h01, k[2:0]}, 1'b1);
      host_u.q = 40;
      host_u.start;
      check({7'h00, hs_mode_q}, 8'h01);
      if (k == 7) begin
        snd(8'hd6, 1'b0);
        snd(8'h10, 1'b0);
        snd(8'h5a, 1'b0);
        host_u.start;
        check({7'h00, hs_mode_q}, 8'h01);
        snd(8'hd7, 1'b0);
        host_u.recv_byte(1'b0, d);
        check(d, 8'h11);
      end
      host_u.stop;
      repeat (8) @(posedge clk);
      check({7'h00, hs_mode_q}, 8'h00);
    end
    $display("t_hs done");
  endtask
  task wrap_up;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    loc_we = 1'b0;
    loc_addr = 8'h00;
    loc_wdata = 8'h11;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    loc_we <= 1'b1;
    loc_addr <= 8'h11;
    @(posedge clk) loc_we <= 1'b0;
    repeat (3) @(posedge clk);
    t_write;
    t_read;
    t_foreign;
    t_hs;
    wrap_up;
  end
endmodule
bind irs_slave irs_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk_u (
  .clk, .rst, .scl_i, .sda_i, .sda_o_q, .sda_oe_q, .loc_we, .loc_addr,
  .loc_wdata, .loc_rdata_q, .wr_stb_q, .wr_addr_q, .wr_data_q, .rd_stb_q,
  .hs_mode_q, .selected_q);
